/* rtl/rscf_pkg.sv */
// package for the reset state and cause flag block
// assumes a single 125 MHz system clock domain
package rscf_pkg;
    localparam logic [7:0] RSCF_VSEL_RST = 8'h55;
    localparam logic [7:0] RSCF_RCTL_RST = 8'h55;
    localparam logic [7:0] RSCF_PA_RST = 8'hf7;
    localparam logic [7:0] RSCF_PA_MASK = 8'hf7;
    localparam logic [10:0] RSCF_PC_RST = 11'h000;
    localparam logic [2:0] RSCF_SP_RST = 3'h0;
    localparam logic [2:0] RSCF_SP_TOP = 3'h7;
    localparam logic [7:0] RSCF_INTEN_RST = 8'h00;
    localparam logic RSCF_FLAG_CLR = 1'b0;
    localparam logic RSCF_FLAG_SET = 1'b1;
    localparam logic [7:0] RSCF_AV_VSEL = 8'h00;
    localparam logic [7:0] RSCF_AV_RCTL = 8'h04;
    localparam logic [7:0] RSCF_AV_PA = 8'h08;
    localparam logic [7:0] RSCF_AV_PADIR = 8'h0c;
    localparam logic [7:0] RSCF_AV_STATUS = 8'h10;
    localparam logic [7:0] RSCF_AV_CORE = 8'h14;

    typedef enum logic [2:0] {
        RSCF_NONE, RSCF_POR, RSCF_PIN_LVR, RSCF_WDT_RUN, RSCF_WDT_SLEEP
    } rscf_kind_t;

    typedef struct packed {
        logic ext_pin_n;
        logic low_voltage;
        logic wdt_timeout;
        logic sleeping;
    } rscf_req_t;
endpackage : rscf_pkg

/* rtl/rscf_top.sv */
// reset state and cause flag logic: classifies reset requests and loads
// the core state each reset kind defines; registers on avalon-mm
// assumes rst_n is the power-on reset and other sources are asynchronous
`timescale 1ns/10ps
module rscf_top
    import rscf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire rscf_req_t req_async,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic avs_readdatavalid_unused,
    output logic [10:0] pc,
    output logic [2:0] stack_ptr,
    output logic [7:0] int_enable,
    output logic wdt_clear,
    output logic timer_on,
    output logic timeout_flag,
    output logic powerdown_flag,
    output logic [7:0] voltage_select_reg,
    output logic [7:0] reset_control_reg,
    output logic [7:0] port_a_data,
    output logic [7:0] port_a_direction
);
    rscf_req_t sync1, sync2, prev;
    logic por_pend;
    rscf_kind_t kind;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= '{ext_pin_n: 1'b1, default: 1'b0};
            sync2 <= '{ext_pin_n: 1'b1, default: 1'b0};
            prev <= '{ext_pin_n: 1'b1, default: 1'b0};
        end else begin
            sync1 <= req_async;
            sync2 <= sync1;
            prev <= sync2;
        end
    end

    // power-on reset handled as one event on the first edge after release
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) por_pend <= 1'b1;
        else por_pend <= 1'b0;
    end

    function automatic rscf_kind_t classify(logic por, rscf_req_t s, rscf_req_t p);
        logic pin_ev;
        logic wdt_ev;
        pin_ev = (!s.ext_pin_n && p.ext_pin_n) || (s.low_voltage && !p.low_voltage);
        wdt_ev = s.wdt_timeout && !p.wdt_timeout;
        if (por) return RSCF_POR;
        if (pin_ev) return RSCF_PIN_LVR;
        if (wdt_ev && s.sleeping) return RSCF_WDT_SLEEP;
        if (wdt_ev) return RSCF_WDT_RUN;
        return RSCF_NONE;
    endfunction : classify

    always_comb kind = classify(por_pend, sync2, prev);

    logic wr_hit;
    assign wr_hit = avs_write && !avs_waitrequest;

    // cause flags
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            timeout_flag <= RSCF_FLAG_CLR;
            powerdown_flag <= RSCF_FLAG_CLR;
        end else begin
            unique case (kind)
                RSCF_POR: begin
                    timeout_flag <= RSCF_FLAG_CLR;
                    powerdown_flag <= RSCF_FLAG_CLR;
                end
                RSCF_PIN_LVR: ;
                RSCF_WDT_RUN: timeout_flag <= RSCF_FLAG_SET;
                RSCF_WDT_SLEEP: begin
                    timeout_flag <= RSCF_FLAG_SET;
                    powerdown_flag <= RSCF_FLAG_SET;
                end
                RSCF_NONE: if (wr_hit && avs_address == RSCF_AV_STATUS) begin
                    timeout_flag <= avs_writedata[1];
                    powerdown_flag <= avs_writedata[0];
                end
            endcase
        end
    end

    // core state: pc and stack pointer
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pc <= RSCF_PC_RST;
            stack_ptr <= RSCF_SP_TOP;
        end else if (kind == RSCF_WDT_SLEEP) begin
            pc <= RSCF_PC_RST;
            stack_ptr <= RSCF_SP_RST;
        end else if (kind != RSCF_NONE) begin
            pc <= RSCF_PC_RST;
            stack_ptr <= RSCF_SP_TOP;
        end else if (wr_hit && avs_address == RSCF_AV_CORE) begin
            pc <= avs_writedata[10:0];
            stack_ptr <= avs_writedata[18:16];
        end
    end

    // interrupt enables, timer, watchdog clear
    logic reinit;
    assign reinit = (kind == RSCF_POR) || (kind == RSCF_PIN_LVR) || (kind == RSCF_WDT_RUN);
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            int_enable <= RSCF_INTEN_RST;
            timer_on <= 1'b0;
            wdt_clear <= 1'b1;
        end else begin
            wdt_clear <= (kind == RSCF_POR);
            if (reinit) begin
                int_enable <= RSCF_INTEN_RST;
                timer_on <= 1'b0;
            end else if (wr_hit && avs_address == RSCF_AV_CORE) begin
                int_enable <= avs_writedata[31:24];
                timer_on <= avs_writedata[20];
            end
        end
    end

    // fixed registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            voltage_select_reg <= RSCF_VSEL_RST;
            reset_control_reg <= RSCF_RCTL_RST;
            port_a_data <= RSCF_PA_RST;
            port_a_direction <= RSCF_PA_RST;
        end else if (reinit) begin
            voltage_select_reg <= RSCF_VSEL_RST;
            reset_control_reg <= RSCF_RCTL_RST;
            port_a_data <= RSCF_PA_RST;
            port_a_direction <= RSCF_PA_RST;
        end else if (wr_hit) begin
            unique case (avs_address)
                RSCF_AV_VSEL: voltage_select_reg <= avs_writedata[7:0];
                RSCF_AV_RCTL: reset_control_reg <= avs_writedata[7:0];
                RSCF_AV_PA: port_a_data <= avs_writedata[7:0] & RSCF_PA_MASK;
                RSCF_AV_PADIR: port_a_direction <= avs_writedata[7:0] & RSCF_PA_MASK;
                default: ;
            endcase
        end
    end

    // avalon slave: one wait cycle per access
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
            avs_readdatavalid_unused <= 1'b0;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            avs_readdatavalid_unused <= 1'b0;
            if (avs_read && avs_waitrequest) begin
                unique case (avs_address)
                    RSCF_AV_VSEL: avs_readdata <= {24'h00_0000, voltage_select_reg};
                    RSCF_AV_RCTL: avs_readdata <= {24'h00_0000, reset_control_reg};
                    RSCF_AV_PA: avs_readdata <= {24'h00_0000, port_a_data};
                    RSCF_AV_PADIR: avs_readdata <= {24'h00_0000, port_a_direction};
                    RSCF_AV_STATUS: avs_readdata <= {30'h0000_0000, timeout_flag,
                        powerdown_flag};
                    RSCF_AV_CORE: avs_readdata <= {int_enable, 3'h0, timer_on, 1'b0,
                        stack_ptr, 5'h00, pc};
                    default: avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    a_sleep_flags: assert property (@(posedge clk_sys) disable iff (!rst_n)
        kind == RSCF_WDT_SLEEP |=> timeout_flag && powerdown_flag && pc == RSCF_PC_RST
        && stack_ptr == RSCF_SP_RST)
        else $error("sleep watchdog state wrong");
    a_pin_keep: assert property (@(posedge clk_sys) disable iff (!rst_n)
        kind == RSCF_PIN_LVR |=> $stable(timeout_flag) && $stable(powerdown_flag))
        else $error("pin reset changed flags");
    a_run_wdt: assert property (@(posedge clk_sys) disable iff (!rst_n)
        kind == RSCF_WDT_RUN |=> timeout_flag && $stable(powerdown_flag))
        else $error("running watchdog flags wrong");
    a_por_int: assert property (@(posedge clk_sys) disable iff (!rst_n)
        kind == RSCF_POR |=> int_enable == RSCF_INTEN_RST && !timer_on)
        else $error("por left interrupts or timer on");
    a_por_wdt: assert property (@(posedge clk_sys) disable iff (!rst_n)
        kind == RSCF_POR |=> wdt_clear ##1 !wdt_clear)
        else $error("watchdog clear not one pulse");
    a_por_ports: assert property (@(posedge clk_sys) disable iff (!rst_n)
        kind == RSCF_POR |=> port_a_direction == RSCF_PA_RST && stack_ptr == RSCF_SP_TOP)
        else $error("por port or stack wrong");
    a_sleep_keep: assert property (@(posedge clk_sys) disable iff (!rst_n)
        kind == RSCF_WDT_SLEEP |=> $stable(voltage_select_reg) && $stable(port_a_data))
        else $error("sleep watchdog changed registers");
    a_prio: assert property (@(posedge clk_sys) disable iff (!rst_n)
        por_pend |=> !timeout_flag && !powerdown_flag && pc == RSCF_PC_RST
        && stack_ptr == RSCF_SP_TOP)
        else $error("por state wrong");
    a_pin_wdt_prio: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !por_pend && !sync2.ext_pin_n && prev.ext_pin_n && sync2.wdt_timeout
        && !prev.wdt_timeout |=> $stable(timeout_flag) && $stable(powerdown_flag))
        else $error("watchdog beat pin reset");
endmodule : rscf_top

/* tb/rscf_top_tb_top.sv */
// self-checking bench for the reset state and cause flag block
// assumes the avalon-mm map and reset values given by the block's package
`timescale 1ns/10ps
module rscf_top_tb_top;
    import rscf_pkg::*;
    localparam rscf_req_t REQ_IDLE = 4'b1000;
    logic clk_sys, rst_n, avs_read, avs_write, avs_waitrequest;
    rscf_req_t req_async;
    logic [7:0] avs_address, int_enable, voltage_select_reg, reset_control_reg;
    logic [7:0] port_a_data, port_a_direction;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [10:0] pc;
    logic [2:0] stack_ptr;
    logic wdt_clear, timer_on, timeout_flag, powerdown_flag, rdv_unused;
    int num_errors = 0, n_compared = 0, cycles = 0;
    rscf_top uut (.clk_sys(clk_sys), .rst_n(rst_n), .req_async(req_async),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_readdatavalid_unused(rdv_unused), .pc(pc),
        .stack_ptr(stack_ptr), .int_enable(int_enable), .wdt_clear(wdt_clear),
        .timer_on(timer_on), .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag),
        .voltage_select_reg(voltage_select_reg), .reset_control_reg(reset_control_reg),
        .port_a_data(port_a_data), .port_a_direction(port_a_direction));
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    // waits for the slave without a limit of its own; the cycle ceiling ends a hang
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk_sys);
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    // hold a request long enough for sync and edge detect, then release
    task fire(input rscf_req_t r);
        @(posedge clk_sys);
        req_async <= r;
        repeat (6) @(posedge clk_sys);
        req_async <= REQ_IDLE;
        repeat (4) @(posedge clk_sys);
    endtask : fire
    task setup(input logic [1:0] st);
        bus(1'b1, RSCF_AV_VSEL, 32'h0000_0033);
        bus(1'b1, RSCF_AV_RCTL, 32'h0000_00aa);
        bus(1'b1, RSCF_AV_PA, 32'h0000_0012);
        bus(1'b1, RSCF_AV_PADIR, 32'h0000_0000);
        bus(1'b1, RSCF_AV_STATUS, {30'h0000_0000, st});
        bus(1'b1, RSCF_AV_CORE, 32'h8015_0123);
    endtask : setup
    task chk_fixed;
        chk(voltage_select_reg, RSCF_VSEL_RST, "vsel");
        chk(reset_control_reg, RSCF_RCTL_RST, "rctl");
        chk(port_a_data, RSCF_PA_RST, "pa");
        chk(port_a_direction, RSCF_PA_RST, "padir");
    endtask : chk_fixed
    task t_por;
        chk(pc, RSCF_PC_RST, "pc");
        chk(rdv_unused, 1'b0, "readdatavalid");
        chk(stack_ptr, RSCF_SP_TOP, "sp");
        chk(int_enable, RSCF_INTEN_RST, "inten");
        chk(timer_on, 1'b0, "timer");
        chk(wdt_clear, 1'b0, "wdt clear end");
        chk({timeout_flag, powerdown_flag}, 2'b00, "flags");
        chk_fixed();
        bus(1'b1, 8'hfc, 32'h0000_0011);
        bus(1'b0, 8'hfc, 32'h0000_0000);
        chk(rd, 32'h0000_0000, "unmapped read");
        chk(voltage_select_reg, RSCF_VSEL_RST, "unmapped write");
    endtask : t_por
    task t_pin_lvr;
        setup(2'b10);
        fire(4'b0000);
        chk({timeout_flag, powerdown_flag}, 2'b10, "pin flags");
        chk(pc, 32'h0000_0000, "pin pc");
        chk_fixed();
        bus(1'b0, RSCF_AV_STATUS, 32'h0000_0000);
        chk(rd[1:0], 2'b10, "status read");
        setup(2'b01);
        fire(4'b1100);
        chk({timeout_flag, powerdown_flag}, 2'b01, "lvr flags");
        chk_fixed();
    endtask : t_pin_lvr
    task t_wdt_run;
        setup(2'b01);
        fire(4'b1010);
        chk({timeout_flag, powerdown_flag}, 2'b11, "wdt flags");
        chk_fixed();
        setup(2'b00);
        fire(4'b1010);
        chk({timeout_flag, powerdown_flag}, 2'b10, "wdt flags2");
    endtask : t_wdt_run
    task t_wdt_sleep;
        setup(2'b00);
        fire(4'b1011);
        chk({pc, stack_ptr}, 14'h0000, "sleep pc sp");
        chk({timeout_flag, powerdown_flag}, 2'b11, "sleep flags");
        chk({voltage_select_reg, reset_control_reg}, 16'h33aa, "sleep vsel rctl");
        chk({port_a_data, port_a_direction}, 16'h1200, "sleep port");
        chk({int_enable, 3'b000, timer_on}, 12'h801, "sleep core");
    endtask : t_wdt_sleep
    // power-on reset in mid-run, after flags and registers were changed
    task t_reset;
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_por();
    endtask : t_reset
    task t_prio;
        setup(2'b00);
        fire(4'b0010);
        chk({timeout_flag, powerdown_flag}, 2'b00, "prio flags");
        chk_fixed();
    endtask : t_prio
    task summarize;
        if (num_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            summarize();
        end
    end
    initial begin
        rst_n = 1'b0;
        req_async = REQ_IDLE;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        repeat (3) @(posedge clk_sys);
        chk(wdt_clear, 1'b1, "wdt clear in reset");
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_por();
        t_pin_lvr();
        t_wdt_run();
        t_wdt_sleep();
        t_reset();
        t_prio();
        summarize();
    end
endmodule : rscf_top_tb_top
